/* design/nested_vectored_irq_controller_pkg.sv */
// Package for the nested vectored interrupt controller: register map, field layout,
// reset values and the shared carrier types.
// Assumes a 32-bit byte-addressed register port with word accesses on the private peripheral bus.
package nested_vectored_irq_controller_pkg;
    localparam int NESTED_VECTORED_IRQ_CONTROLLER_NUM_IRQ = 32;
    localparam logic [31:0] NESTED_VECTORED_IRQ_CONTROLLER_ADDR_ENABLE_SET = 32'he000e100;
    localparam logic [31:0] NESTED_VECTORED_IRQ_CONTROLLER_ADDR_ENABLE_CLEAR = 32'he000e180;
    localparam logic [31:0] NESTED_VECTORED_IRQ_CONTROLLER_ADDR_PENDING_SET = 32'he000e200;
    localparam logic [31:0] NESTED_VECTORED_IRQ_CONTROLLER_ADDR_PENDING_CLEAR = 32'he000e280;
    localparam logic [31:0] NESTED_VECTORED_IRQ_CONTROLLER_ADDR_PRIORITY_BASE = 32'he000e400;
    localparam logic [31:0] NESTED_VECTORED_IRQ_CONTROLLER_ADDR_PRIORITY_LAST = 32'he000e41c;
    localparam logic [31:0] NESTED_VECTORED_IRQ_CONTROLLER_RST_ENABLE = 32'h00000000;
    localparam logic [31:0] NESTED_VECTORED_IRQ_CONTROLLER_RST_PENDING = 32'h00000000;
    localparam logic [31:0] NESTED_VECTORED_IRQ_CONTROLLER_RST_PRIORITY = 32'h00000000;
    // The two implemented priority bits sit at the top of each byte lane.
    localparam int NESTED_VECTORED_IRQ_CONTROLLER_PRIO_LSB = 6;
    localparam int NESTED_VECTORED_IRQ_CONTROLLER_PRIO_W = 2;
    localparam logic [2:0] NESTED_VECTORED_IRQ_CONTROLLER_NO_ACTIVE_LEVEL = 3'h4;
    localparam logic [1:0] NESTED_VECTORED_IRQ_CONTROLLER_PRIO_LOWEST = 2'h3;

    typedef enum logic [1:0] {
        NESTED_VECTORED_IRQ_CONTROLLER_ST_THREAD = 2'b00,
        NESTED_VECTORED_IRQ_CONTROLLER_ST_STACK = 2'b01,
        NESTED_VECTORED_IRQ_CONTROLLER_ST_HANDLER = 2'b11,
        NESTED_VECTORED_IRQ_CONTROLLER_ST_UNSTACK = 2'b10
    } nested_vectored_irq_controller_state_e;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [31:0] addr;
        logic [31:0] wdata;
    } nested_vectored_irq_controller_reg_req_s;

    typedef struct packed {
        logic take_valid;
        logic take_nmi;
        logic [4:0] take_irq;
    } nested_vectored_irq_controller_take_s;
endpackage : nested_vectored_irq_controller_pkg

/* design/nested_vectored_irq_controller_prio_select.sv */
// Priority arbiter: picks the most urgent pending and enabled interrupt.
// Assumes priority levels are already unpacked, two bits per line.
`timescale 1ns/1ps
`default_nettype none
module nested_vectored_irq_controller_prio_select
    import nested_vectored_irq_controller_pkg::*;
(
    input wire logic [31:0] cand, // Pending and enabled lines.
    input wire logic [63:0] prio, // Two-bit level per line.
    output logic found, // A candidate exists.
    output logic [4:0] best_irq, // Winning line number.
    output logic [1:0] best_prio // Winning level.
);
    always_comb begin
        found = 1'b0;
        best_irq = 5'h00;
        best_prio = NESTED_VECTORED_IRQ_CONTROLLER_PRIO_LOWEST;
        // Strict less-than keeps the lowest line number on a tie.
        for (int i = 0; i < NESTED_VECTORED_IRQ_CONTROLLER_NUM_IRQ; i++) begin
            if (cand[i] && (!found || prio[2*i +: 2] < best_prio)) begin
                found = 1'b1;
                best_irq = 5'(i);
                best_prio = prio[2*i +: 2];
            end
        end
    end
endmodule : nested_vectored_irq_controller_prio_select
`default_nettype wire

/* design/nested_vectored_irq_controller_core.sv */
// Nested vectored interrupt controller top: registers, pending capture,
// selection (non-maskable first, then by priority, lowest line on a tie) in thread or at handler return, and core entry/exit sequencing.
// Assumes the core's private bus gives single-cycle word accesses and
// that the core reports the end of stacking, handler return and unstacking.
//
// Function
// - Thirty-two maskable interrupt inputs, enable bit n belongs to interrupt n.
// - Each interrupt has priority 0, 64, 128 or 192.
// - Larger priority number is less urgent; zero is most urgent.
// - Level or pulse requests are both latched as pending.
// - One non-maskable input that the enable bits cannot block.
// - State is stacked by hardware on exception entry.
// - State is unstacked by hardware on exception exit.
// - Set-enable writes of one enable, zero ignored; read shows enables.
// - Pending and enabled lines are chosen by priority, lowest line number on a tie, in thread or at handler return.
// - Disabled lines still go pending but are never activated.
// - Clear-enable writes of one disable; read shows enables.
`timescale 1ns/1ps
`default_nettype none
module nested_vectored_irq_controller_core
    import nested_vectored_irq_controller_pkg::*;
(
    input wire logic clk_sys, // Core clock, 125 MHz.
    input wire logic sys_rst, // Synchronous reset, active high.
    input wire nested_vectored_irq_controller_reg_req_s reg_req, // Register access from the core.
    output logic [31:0] reg_rdata, // Read data, valid the cycle after rd.
    input wire logic [31:0] irq_in, // Peripheral requests, level or pulse.
    input wire logic nmi_in, // External non-maskable request.
    output nested_vectored_irq_controller_take_s take, // Exception to enter, valid during stacking.
    output logic stack_req, // Hardware stacking in progress.
    output logic unstack_req, // Hardware unstacking in progress.
    output logic tail_chain, // Pulse: next handler entered without unstacking.
    input wire logic stack_done, // Core finished stacking.
    input wire logic handler_ret, // Pulse: handler returned.
    input wire logic unstack_done, // Core finished unstacking.
    output logic [2:0] exec_level // Current execution level, 4 means thread.
);
    logic [31:0] enable, next_enable;
    logic [31:0] pending, next_pending;
    logic [63:0] prio, next_prio;
    logic [31:0] irq_prev, next_irq_prev;
    logic nmi_prev, next_nmi_prev;
    logic nmi_pend, next_nmi_pend;
    logic [31:0] next_rdata;
    nested_vectored_irq_controller_state_e state, next_state;
    nested_vectored_irq_controller_take_s next_take;
    logic next_tail_chain;
    logic [31:0] irq_rise;
    logic found;
    logic [4:0] best_irq;
    logic [1:0] best_prio;
    logic [2:0] next_exec_level;
    logic [2:0] prio_idx;

    assign irq_rise = irq_in & ~irq_prev;
    // Word k of the priority block holds lines 4k to 4k+3, one per byte lane.
    assign prio_idx = reg_req.addr[4:2];

    // Only lines that are both pending and enabled reach the arbiter.
    nested_vectored_irq_controller_prio_select u_sel (
        .cand(pending & enable),
        .prio(prio),
        .found(found),
        .best_irq(best_irq),
        .best_prio(best_prio)
    );

    // Edge history for pulse capture and for the non-maskable request.
    always_comb begin
        next_irq_prev = irq_in;
        next_nmi_prev = nmi_in;
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            irq_prev <= 32'h00000000;
            nmi_prev <= 1'b0;
        end else begin
            irq_prev <= next_irq_prev;
            nmi_prev <= next_nmi_prev;
        end
    end

    // Read data stands for one cycle and then falls back to zero.
    always_comb begin
        next_rdata = 32'h00000000;
        if (reg_req.rd) begin
            case (reg_req.addr)
                NESTED_VECTORED_IRQ_CONTROLLER_ADDR_ENABLE_SET, NESTED_VECTORED_IRQ_CONTROLLER_ADDR_ENABLE_CLEAR: next_rdata = enable;
                NESTED_VECTORED_IRQ_CONTROLLER_ADDR_PENDING_SET, NESTED_VECTORED_IRQ_CONTROLLER_ADDR_PENDING_CLEAR: next_rdata = pending;
                default: begin
                    if (reg_req.addr >= NESTED_VECTORED_IRQ_CONTROLLER_ADDR_PRIORITY_BASE &&
                        reg_req.addr <= NESTED_VECTORED_IRQ_CONTROLLER_ADDR_PRIORITY_LAST &&
                        reg_req.addr[1:0] == 2'h0) begin
                        for (int b = 0; b < 4; b++) begin
                            next_rdata[b*8 + NESTED_VECTORED_IRQ_CONTROLLER_PRIO_LSB +: NESTED_VECTORED_IRQ_CONTROLLER_PRIO_W] =
                                prio[(prio_idx * 4 + b) * 2 +: 2];
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            reg_rdata <= 32'h00000000;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    always_comb begin
        next_enable = enable;
        next_pending = pending;
        next_prio = prio;
        next_nmi_pend = nmi_pend | (nmi_in & ~nmi_prev);
        if (reg_req.wr) begin
            case (reg_req.addr)
                NESTED_VECTORED_IRQ_CONTROLLER_ADDR_ENABLE_SET: next_enable = enable | reg_req.wdata;
                NESTED_VECTORED_IRQ_CONTROLLER_ADDR_ENABLE_CLEAR: next_enable = enable & ~reg_req.wdata;
                NESTED_VECTORED_IRQ_CONTROLLER_ADDR_PENDING_SET: next_pending = pending | reg_req.wdata;
                NESTED_VECTORED_IRQ_CONTROLLER_ADDR_PENDING_CLEAR: next_pending = pending & ~reg_req.wdata;
                default: begin
                    if (reg_req.addr >= NESTED_VECTORED_IRQ_CONTROLLER_ADDR_PRIORITY_BASE &&
                        reg_req.addr <= NESTED_VECTORED_IRQ_CONTROLLER_ADDR_PRIORITY_LAST &&
                        reg_req.addr[1:0] == 2'h0) begin
                        for (int b = 0; b < 4; b++) begin
                            next_prio[(prio_idx * 4 + b) * 2 +: 2] =
                                reg_req.wdata[b*8 + NESTED_VECTORED_IRQ_CONTROLLER_PRIO_LSB +: NESTED_VECTORED_IRQ_CONTROLLER_PRIO_W];
                        end
                    end
                end
            endcase
        end
        // Hardware events are applied after software clears so a set wins.
        next_pending = next_pending | irq_in | irq_rise;
        // Arbitration runs only in thread and at handler return, so no handler is preempted.
        next_state = state;
        next_take = take;
        next_tail_chain = 1'b0;
        next_exec_level = exec_level;
        case (state)
            NESTED_VECTORED_IRQ_CONTROLLER_ST_THREAD: begin
                if (nmi_pend) begin
                    next_take = '{take_valid: 1'b1, take_nmi: 1'b1, take_irq: 5'h00};
                    // An edge arriving as the request is taken stays pending.
                    next_nmi_pend = nmi_in & ~nmi_prev;
                    next_state = NESTED_VECTORED_IRQ_CONTROLLER_ST_STACK;
                end else if (found) begin
                    next_take = '{take_valid: 1'b1, take_nmi: 1'b0, take_irq: best_irq};
                    next_pending[best_irq] = 1'b0;
                    next_exec_level = {1'b0, best_prio};
                    next_state = NESTED_VECTORED_IRQ_CONTROLLER_ST_STACK;
                end
            end
            NESTED_VECTORED_IRQ_CONTROLLER_ST_STACK: begin
                if (stack_done) begin
                    next_state = NESTED_VECTORED_IRQ_CONTROLLER_ST_HANDLER;
                end
            end
            NESTED_VECTORED_IRQ_CONTROLLER_ST_HANDLER: begin
                if (handler_ret) begin
                    if (nmi_pend) begin
                        next_take = '{take_valid: 1'b1, take_nmi: 1'b1, take_irq: 5'h00};
                        next_nmi_pend = nmi_in & ~nmi_prev;
                        next_tail_chain = 1'b1;
                    end else if (found) begin
                        next_take = '{take_valid: 1'b1, take_nmi: 1'b0, take_irq: best_irq};
                        next_pending[best_irq] = 1'b0;
                        next_exec_level = {1'b0, best_prio};
                        next_tail_chain = 1'b1;
                    end else begin
                        next_take = '{take_valid: 1'b0, take_nmi: 1'b0, take_irq: 5'h00};
                        next_state = NESTED_VECTORED_IRQ_CONTROLLER_ST_UNSTACK;
                    end
                end
            end
            NESTED_VECTORED_IRQ_CONTROLLER_ST_UNSTACK: begin
                if (unstack_done) begin
                    next_exec_level = NESTED_VECTORED_IRQ_CONTROLLER_NO_ACTIVE_LEVEL;
                    next_state = NESTED_VECTORED_IRQ_CONTROLLER_ST_THREAD;
                end
            end
            default: next_state = NESTED_VECTORED_IRQ_CONTROLLER_ST_THREAD;
        endcase
        // A line still asserted keeps pending after being taken, as a level must.
        if (next_take.take_valid && !next_take.take_nmi && state != NESTED_VECTORED_IRQ_CONTROLLER_ST_STACK &&
            (state == NESTED_VECTORED_IRQ_CONTROLLER_ST_THREAD || handler_ret)) begin
            next_pending[next_take.take_irq] = irq_in[next_take.take_irq];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            enable <= NESTED_VECTORED_IRQ_CONTROLLER_RST_ENABLE;
            pending <= NESTED_VECTORED_IRQ_CONTROLLER_RST_PENDING;
            prio <= {2{NESTED_VECTORED_IRQ_CONTROLLER_RST_PRIORITY}};
            nmi_pend <= 1'b0;
            state <= NESTED_VECTORED_IRQ_CONTROLLER_ST_THREAD;
            take <= '0;
            tail_chain <= 1'b0;
            exec_level <= NESTED_VECTORED_IRQ_CONTROLLER_NO_ACTIVE_LEVEL;
        end else begin
            enable <= next_enable;
            pending <= next_pending;
            prio <= next_prio;
            nmi_pend <= next_nmi_pend;
            state <= next_state;
            take <= next_take;
            tail_chain <= next_tail_chain;
            exec_level <= next_exec_level;
        end
    end

    // Both requests decode the state register, so they change only at a clock edge.
    assign stack_req = (state == NESTED_VECTORED_IRQ_CONTROLLER_ST_STACK);
    assign unstack_req = (state == NESTED_VECTORED_IRQ_CONTROLLER_ST_UNSTACK);
endmodule : nested_vectored_irq_controller_core
`default_nettype wire

/* verif/nested_vectored_irq_controller_core_asserts.sv */
// Concurrent checks on the interrupt controller top, bound onto nested_vectored_irq_controller_core.
// Assumes the nested_vectored_irq_controller_pkg types; sees only the top module's ports.
`timescale 1ns/1ps
`default_nettype none
module nested_vectored_irq_controller_core_asserts
    import nested_vectored_irq_controller_pkg::*;
(
    input wire logic clk_sys, // Core clock.
    input wire logic sys_rst, // Synchronous reset.
    input wire nested_vectored_irq_controller_reg_req_s reg_req, // Register access.
    input wire logic [31:0] reg_rdata, // Read data.
    input wire logic nmi_in, // Non-maskable request.
    input wire nested_vectored_irq_controller_take_s take, // Chosen exception.
    input wire logic stack_req, // Stacking busy.
    input wire logic unstack_req, // Unstacking busy.
    input wire logic tail_chain, // Chain pulse.
    input wire logic stack_done, // Stacking finished.
    input wire logic unstack_done, // Unstacking finished.
    input wire logic [2:0] exec_level // Execution level.
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    AST_UNMAPPED_ZERO: assert property (reg_req.rd && reg_req.addr == 32'he000e104
        |=> reg_rdata == 32'h0) else $error("unmapped read not zero");
    AST_CLEAR_READBACK: assert property (reg_req.rd && !reg_req.wr
        && reg_req.addr == NESTED_VECTORED_IRQ_CONTROLLER_ADDR_ENABLE_SET ##1 reg_req.rd && !reg_req.wr
        && reg_req.addr == NESTED_VECTORED_IRQ_CONTROLLER_ADDR_ENABLE_CLEAR |=> reg_rdata == $past(reg_rdata))
        else $error("clear-enable read differs");
    AST_STACK_HOLD: assert property (stack_req && !stack_done |=> stack_req)
        else $error("stacking dropped early");
    AST_STACK_END: assert property (stack_req && stack_done |=> !stack_req && take.take_valid)
        else $error("stacking did not end");
    AST_UNSTACK_END: assert property (unstack_req && unstack_done
        |=> !unstack_req && !take.take_valid && exec_level == 3'h4) else $error("no thread");
    AST_TAIL_DIRECT: assert property (tail_chain |-> take.take_valid && !unstack_req)
        else $error("chain went through unstacking");
    AST_LEVEL_RANGE: assert property (stack_req && !take.take_nmi
        |-> take.take_valid && exec_level <= 3'h3) else $error("bad level");
    AST_NMI_TAKE: assert property ($rose(nmi_in) && !take.take_valid && !unstack_req
        |=> ##[0:2] take.take_valid && take.take_nmi) else $error("nmi not taken");
    cover property (tail_chain);
    cover property (take.take_nmi && stack_req);
    cover property (unstack_req && unstack_done);
endmodule : nested_vectored_irq_controller_core_asserts
bind nested_vectored_irq_controller_core nested_vectored_irq_controller_core_asserts u_asserts (.clk_sys, .sys_rst, .reg_req, .reg_rdata, .nmi_in,
    .take, .stack_req, .unstack_req, .tail_chain, .stack_done, .unstack_done, .exec_level);
`default_nettype wire

/* verif/nested_vectored_irq_controller_cpu_model.sv */
// Behavioural core: ends stacking and unstacking after wait_cyc cycles.
// Assumes the bench drives handler returns itself.
`timescale 1ns/1ps
`default_nettype none
module nested_vectored_irq_controller_cpu_model (
    input wire logic clk_sys, // Core clock.
    input wire logic sys_rst, // Synchronous reset.
    input wire logic stack_req, // Stacking asked.
    input wire logic unstack_req, // Unstacking asked.
    input wire logic [1:0] wait_cyc, // Cycles before done.
    output logic stack_done, // Stacking finished.
    output logic unstack_done // Unstacking finished.
);
    logic [1:0] cnt = 2'h0;
    always @(negedge clk_sys) begin
        if (sys_rst || !(stack_req || unstack_req)) cnt <= 2'h0;
        else if (cnt != wait_cyc) cnt <= cnt + 2'h1;
    end
    assign stack_done = stack_req && cnt == wait_cyc;
    assign unstack_done = unstack_req && cnt == wait_cyc;
endmodule : nested_vectored_irq_controller_cpu_model
`default_nettype wire

/* verif/testbench.sv */
// Self-checking bench for nested_vectored_irq_controller_core with the behavioural core model.
// Assumes the design package and modules are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import nested_vectored_irq_controller_pkg::*;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    nested_vectored_irq_controller_reg_req_s reg_req = '0;
    logic [31:0] irq_in = '0;
    logic [31:0] seed = 32'h8774;
    logic [31:0] reg_rdata, r, v;
    logic nmi_in = 1'b0;
    logic handler_ret = 1'b0;
    logic stack_req, unstack_req, tail_chain, stack_done, unstack_done;
    logic [1:0] wait_cyc = 2'h0;
    logic [2:0] exec_level;
    nested_vectored_irq_controller_take_s take;
    int failures = 0;
    int total_checks = 0;
    int tails = 0;
    initial forever #4 clk_sys = ~clk_sys;
    nested_vectored_irq_controller_core u_nested_vectored_irq_controller_core (.clk_sys, .sys_rst, .reg_req, .reg_rdata, .irq_in, .nmi_in, .take,
        .stack_req, .unstack_req, .tail_chain, .stack_done, .handler_ret, .unstack_done,
        .exec_level);
    nested_vectored_irq_controller_cpu_model u_nested_vectored_irq_controller_cpu_model (.clk_sys, .sys_rst, .stack_req, .unstack_req, .wait_cyc,
        .stack_done, .unstack_done);
    always @(posedge clk_sys) if (tail_chain === 1'b1) tails <= tails + 1;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic finish_test();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : finish_test
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", n, e, g);
            failures++;
        end
    endtask : chk
    // Leaves the request standing so that accesses run back to back.
    task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] d);
        reg_req = '{wr: w, rd: !w, addr: a, wdata: d};
        @(negedge clk_sys);
    endtask : acc
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        acc(1'b0, a, 32'h0);
        chk("reg_rdata", e, reg_rdata);
    endtask : rd
    function automatic bit at(input logic nmi, input logic [4:0] irq, input logic [2:0] lvl);
        if (lvl == 3'h4 && !nmi) return exec_level === 3'h4 && take.take_valid === 1'b0;
        return take.take_valid === 1'b1 && stack_req === 1'b0 && take.take_nmi === nmi
            && (nmi || take.take_irq === irq);
    endfunction : at
    // Waits for a handler (or thread when lvl is 4 and nmi is 0) and returns from the handler.
    task automatic serve(input logic nmi, input logic [4:0] irq, input logic [2:0] lvl);
        int i;
        for (i = 0; i < 40 && !at(nmi, irq, lvl); i++) @(negedge clk_sys);
        if (i == 40) begin
            $display("MISMATCH take expected %h seen %h", irq, take);
            failures++;
            finish_test();
        end
        chk("exec_level", {29'h0, lvl}, {29'h0, exec_level});
        if (nmi || lvl != 3'h4) begin
            handler_ret = 1'b1;
            @(negedge clk_sys);
            handler_ret = 1'b0;
            @(negedge clk_sys);
        end
    endtask : serve
    initial begin
        repeat (20000) @(posedge clk_sys);
        $display("MISMATCH run expected end seen timeout");
        failures++;
        finish_test();
    end
    initial begin
        repeat (20) @(negedge clk_sys);
        sys_rst = 1'b0;
        for (int k = 0; k < 6; k++) rd(32'he000e100 + 32'h80 * k, 32'h0);
        v = '0;
        repeat (4) begin
            seed = lfsr(seed);
            r = lfsr(seed);
            acc(1'b1, NESTED_VECTORED_IRQ_CONTROLLER_ADDR_ENABLE_SET, seed);
            acc(1'b1, NESTED_VECTORED_IRQ_CONTROLLER_ADDR_ENABLE_SET, 32'h0);
            v = v | seed;
            rd(NESTED_VECTORED_IRQ_CONTROLLER_ADDR_ENABLE_SET, v);
            rd(NESTED_VECTORED_IRQ_CONTROLLER_ADDR_ENABLE_CLEAR, v);
            acc(1'b1, NESTED_VECTORED_IRQ_CONTROLLER_ADDR_ENABLE_CLEAR, r);
            v = v & ~r;
            rd(NESTED_VECTORED_IRQ_CONTROLLER_ADDR_ENABLE_SET, v);
        end
        rd(32'he000e104, 32'h0);
        acc(1'b1, NESTED_VECTORED_IRQ_CONTROLLER_ADDR_ENABLE_CLEAR, 32'hffffffff);
        for (int k = 0; k < 8; k++) begin
            seed = lfsr(seed);
            acc(1'b1, NESTED_VECTORED_IRQ_CONTROLLER_ADDR_PENDING_SET, seed);
            acc(1'b1, NESTED_VECTORED_IRQ_CONTROLLER_ADDR_PENDING_CLEAR, ~(seed & 32'h00000020));
            rd(NESTED_VECTORED_IRQ_CONTROLLER_ADDR_PENDING_SET, seed & 32'h20);
            acc(1'b1, NESTED_VECTORED_IRQ_CONTROLLER_ADDR_PRIORITY_BASE + 4 * k, seed);
            rd(NESTED_VECTORED_IRQ_CONTROLLER_ADDR_PRIORITY_BASE + 4 * k, seed & 32'hc0c0c0c0);
        end
        acc(1'b1, NESTED_VECTORED_IRQ_CONTROLLER_ADDR_PENDING_CLEAR, 32'hffffffff);
        irq_in[5] = 1'b1;
        acc(1'b1, NESTED_VECTORED_IRQ_CONTROLLER_ADDR_PENDING_CLEAR, 32'h20);
        repeat (3) rd(NESTED_VECTORED_IRQ_CONTROLLER_ADDR_PENDING_SET, 32'h20);
        irq_in[5] = 1'b0;
        chk("take_valid", 32'h0, {31'h0, take.take_valid});
        acc(1'b1, NESTED_VECTORED_IRQ_CONTROLLER_ADDR_PENDING_CLEAR, 32'h20);
        rd(NESTED_VECTORED_IRQ_CONTROLLER_ADDR_PENDING_SET, 32'h0);
        acc(1'b1, NESTED_VECTORED_IRQ_CONTROLLER_ADDR_PRIORITY_BASE, 32'h0);
        acc(1'b1, NESTED_VECTORED_IRQ_CONTROLLER_ADDR_PRIORITY_BASE + 4, 32'h80000000);
        acc(1'b1, NESTED_VECTORED_IRQ_CONTROLLER_ADDR_PRIORITY_BASE + 8, 32'h00004000);
        acc(1'b1, NESTED_VECTORED_IRQ_CONTROLLER_ADDR_PRIORITY_BASE + 12, 32'h00000040);
        wait_cyc = seed[1:0];
        acc(1'b1, NESTED_VECTORED_IRQ_CONTROLLER_ADDR_PENDING_SET, 32'h00001280);
        acc(1'b1, NESTED_VECTORED_IRQ_CONTROLLER_ADDR_ENABLE_SET, 32'h00001288);
        reg_req = '0;
        serve(1'b0, 5'd9, 3'h1);
        serve(1'b0, 5'd12, 3'h1);
        serve(1'b0, 5'd7, 3'h2);
        serve(1'b0, 5'd0, 3'h4);
        chk("tails", 32'd2, tails);
        wait_cyc = 2'h3;
        irq_in[3] = 1'b1;
        @(negedge clk_sys);
        irq_in[3] = 1'b0;
        @(negedge clk_sys);
        chk("stack_req", {27'h1, 5'd3}, {26'h0, stack_req, take.take_irq});
        serve(1'b0, 5'd3, 3'h0);
        serve(1'b0, 5'd0, 3'h4);
        nmi_in = 1'b1;
        irq_in[3] = 1'b1;
        @(negedge clk_sys);
        nmi_in = 1'b0;
        serve(1'b1, 5'd0, 3'h4);
        irq_in[3] = 1'b0;
        serve(1'b0, 5'd3, 3'h0);
        serve(1'b0, 5'd3, 3'h0);
        serve(1'b0, 5'd0, 3'h4);
        chk("tails", 32'd4, tails);
        finish_test();
    end
endmodule : testbench
`default_nettype wire
